/* include/btp_if.sv */
`timescale 1ns/1ps
// Purpose: command, mask and data link between the two ends
// Assumes: both ends on clk
// Notes:   data moves one beat per cycle
interface btp_if #(parameter int DW = 32, parameter int NB = DW / 8);
   logic cs_n;
   logic [btp_pkg::CA_W-1:0] ca;
   logic ap;
   logic [DW-1:0] wdata;
   logic [NB-1:0] dm;
   logic wvalid;
   logic [DW-1:0] rdata;
   logic rvalid;
   modport ctrl (output cs_n, ca, ap, wdata, dm, wvalid, input rdata, rvalid);
   modport mem (input cs_n, ca, ap, wdata, dm, wvalid, output rdata, rvalid);
endinterface

/* include/btp_pkg.sv */
// Purpose: shared constants and types for the command link between a
//          memory controller end and a memory device end
// Assumes: single clock clk at 50 MHz, sys_rst asynchronous active high
// Notes:   one clk cycle stands for one memory clock cycle
//
// Overview of operation
// - write cut only by write or terminate
// - write interrupt only for burst 8, 16
// - interrupting write even cycles, after tCCD
// - interrupting write may target any bank
// - auto-precharge write never interrupted
// - interrupted write length twice command gap
// - terminate decode cs low, ca 1,1,0,0
// - terminate only within BL/2-1 cycles
// - truncated length twice cycles to terminate
// - terminate affects only latest read/write
// - terminate stops data after latency
// - terminate only even cycles after command
// - one terminate per read or write
// - per-byte mask blocks that byte's write
// - precharge decode cs low, ca 1,1,0,1
// - ca4 all banks, else ca9..ca7 bank
// - bank ready after tRPab or tRPpb
// - read to precharge BL/2 and tRAS
// - tRTP starts BL/2-2 after read
// - write to precharge WL+BL/2+1+RU(tWR/tCK)
// - activate waits tRP after precharge
package btp_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CA_W = 10;
   localparam int NBANK = 8;
   localparam int BA_W = 3;
   localparam int BL_DEFAULT = 8;
   localparam int RL_DEFAULT = 3;
   localparam int WL_DEFAULT = 1;
   localparam int TCCD_CYC = 2;
   localparam int TRPPB_NS = 18;
   localparam int TRPAB_NS = 21;
   localparam int TRAS_NS = 42;
   localparam int TRTP_NS = 8;
   localparam int TWR_NS = 15;
   localparam int TRPPB_CYC = (TRPPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRPAB_CYC = (TRPAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRAS_CYC = (TRAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRTP_CYC = (TRTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TWR_CYC = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
   localparam int AB_BIT = 4;
   localparam int BA_LSB = 7;
   typedef enum logic [2:0] {
      BTP_NOP, BTP_ACT, BTP_RD, BTP_WR, BTP_BST, BTP_PRE
   } btp_cmd_t;
endpackage

/* src/btp_ctrl.sv */
`timescale 1ns/1ps
// Purpose: controller end: issues commands only when spacing allows
// Assumes: user holds request until accepted
// Notes:   req_ready is a one-cycle acceptance pulse
module btp_ctrl
   import btp_pkg::*;
#(
   parameter int DW = 32,
   parameter int NB = DW / 8,
   parameter int RL = RL_DEFAULT,
   parameter int WL = WL_DEFAULT,
   parameter int BL = BL_DEFAULT,
   parameter int EIGHT_BANK = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   btp_if.ctrl lk,
   // user request
   input wire logic req_valid,
   input wire btp_pkg::btp_cmd_t req_cmd,
   input wire logic [BA_W-1:0] req_bank,
   input wire logic req_all,
   input wire logic req_ap,
   input wire logic [DW-1:0] req_wdata,
   input wire logic [NB-1:0] req_dm,
   output logic req_ready,
   // read return
   output logic [DW-1:0] rd_data,
   output logic rd_valid
);
   import btp_pkg::*;
   typedef logic [CNT_W-1:0] btp_cnt_t;
   localparam btp_cnt_t RTP_MIN = CNT_W'(BL / 2 - 2 + (TRTP_CYC > 2 ? TRTP_CYC : 2));
   localparam btp_cnt_t WPRE_BASE = CNT_W'(WL + 1 + TWR_CYC);
   localparam int TRP_AB = EIGHT_BANK != 0 ? TRPAB_CYC : TRPPB_CYC;
   btp_cnt_t rd_age_q [NBANK];
   btp_cnt_t wr_age_q [NBANK];
   btp_cnt_t pre_age_q [NBANK];
   btp_cnt_t act_age_q [NBANK];
   btp_cnt_t trp_need_q [NBANK];
   btp_cnt_t eff_q [NBANK];
   btp_cnt_t col_age_q;
   logic bst_done_q, ap_q, last_ok_q, last_wr_q;
   logic [BA_W-1:0] last_bank_q;
   function automatic btp_cnt_t sat_inc(input btp_cnt_t v);
      return v == CNT_MAX ? v : v + 8'h01;
   endfunction
   // effective-length based precharge limits, per bank
   function automatic btp_cnt_t rtp_of(input btp_cnt_t e);
      return (e >> 1) - 8'h02 + CNT_W'(TRTP_CYC > 2 ? TRTP_CYC : 2);
   endfunction
   function automatic btp_cnt_t wpre_of(input btp_cnt_t e);
      return WPRE_BASE + (e >> 1);
   endfunction
   wire btp_cnt_t col_next = sat_inc(col_age_q);
   // live write blocks all but write and terminate
   wire wr_live = last_ok_q && last_wr_q && !bst_done_q && col_next < CNT_W'(BL / 2);
   wire col_even = !col_next[0];
   wire col_ok = !last_ok_q || (col_next >= CNT_W'(BL / 2)) ||
                 (BL != 4 && !ap_q && col_even && col_next >= CNT_W'(TCCD_CYC));
   wire bst_ok = last_ok_q && !bst_done_q && !ap_q && col_even && col_next <= CNT_W'(BL / 2 - 1);
   logic pre_ok;
   always_comb begin
      pre_ok = 1'b1;
      for (int b = 0; b < NBANK; b++) begin
         if (req_all || BA_W'(b) == req_bank) begin
            if (sat_inc(rd_age_q[b]) < CNT_W'(BL / 2) || sat_inc(rd_age_q[b]) < rtp_of(eff_q[b]) ||
                sat_inc(wr_age_q[b]) < wpre_of(eff_q[b]) || sat_inc(act_age_q[b]) < CNT_W'(TRAS_CYC)) begin
               pre_ok = 1'b0;
            end
         end
      end
   end
   wire act_ok = sat_inc(pre_age_q[req_bank]) >= trp_need_q[req_bank];
   wire is_col = req_cmd == BTP_RD || req_cmd == BTP_WR;
   wire go = req_valid && !req_ready &&
             ((req_cmd == BTP_WR && col_ok) || (req_cmd == BTP_RD && col_ok && !wr_live) ||
              (req_cmd == BTP_BST && bst_ok) ||
              (req_cmd == BTP_PRE && pre_ok && !wr_live) || (req_cmd == BTP_ACT && act_ok && !wr_live));
   logic [CA_W-1:0] ca_d;
   always_comb begin
      ca_d = '0;
      ca_d[BA_LSB +: BA_W] = req_bank;
      case (req_cmd)
         BTP_ACT: ca_d[1:0] = 2'h0;
         BTP_RD: ca_d[2:0] = 3'h5;
         BTP_WR: ca_d[2:0] = 3'h1;
         BTP_BST: ca_d[3:0] = 4'h3;
         BTP_PRE: begin
            ca_d[3:0] = 4'hB;
            ca_d[AB_BIT] = req_all;
         end
         default: ca_d = '0;
      endcase
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk.cs_n <= 1'b1;
         lk.ca <= '0;
         lk.ap <= 1'b0;
         lk.wdata <= '0;
         lk.dm <= '0;
         lk.wvalid <= 1'b0;
         req_ready <= 1'b0;
         rd_data <= '0;
         rd_valid <= 1'b0;
         col_age_q <= CNT_MAX;
         bst_done_q <= 1'b0;
         ap_q <= 1'b0;
         last_ok_q <= 1'b0;
         last_wr_q <= 1'b0;
         last_bank_q <= '0;
         for (int b = 0; b < NBANK; b++) begin
            eff_q[b] <= CNT_W'(BL);
            rd_age_q[b] <= CNT_MAX;
            wr_age_q[b] <= CNT_MAX;
            pre_age_q[b] <= CNT_MAX;
            act_age_q[b] <= CNT_MAX;
            trp_need_q[b] <= '0;
         end
      end else begin
         lk.cs_n <= !go;
         lk.ca <= go ? ca_d : '0;
         lk.ap <= go && is_col && req_ap;
         lk.wdata <= req_wdata;
         lk.dm <= req_dm;
         lk.wvalid <= 1'b1;
         req_ready <= go;
         rd_data <= lk.rdata;
         rd_valid <= lk.rvalid;
         col_age_q <= sat_inc(col_age_q);
         for (int b = 0; b < NBANK; b++) begin
            rd_age_q[b] <= sat_inc(rd_age_q[b]);
            wr_age_q[b] <= sat_inc(wr_age_q[b]);
            pre_age_q[b] <= sat_inc(pre_age_q[b]);
            act_age_q[b] <= sat_inc(act_age_q[b]);
         end
         if (go) begin
            if (is_col) begin
               if (last_ok_q && !bst_done_q && col_next < CNT_W'(BL / 2)) begin
                  eff_q[last_bank_q] <= {col_next[CNT_W-2:0], 1'b0};
               end
               eff_q[req_bank] <= CNT_W'(BL);
               col_age_q <= '0;
               bst_done_q <= 1'b0;
               ap_q <= req_ap;
               last_ok_q <= 1'b1;
               last_wr_q <= req_cmd == BTP_WR;
               last_bank_q <= req_bank;
               if (req_cmd == BTP_RD) begin
                  rd_age_q[req_bank] <= '0;
               end else begin
                  wr_age_q[req_bank] <= '0;
               end
            end else if (req_cmd == BTP_BST) begin
               eff_q[last_bank_q] <= {col_next[CNT_W-2:0], 1'b0};
               bst_done_q <= 1'b1;
            end else if (req_cmd == BTP_ACT) begin
               act_age_q[req_bank] <= '0;
            end else begin
               for (int b = 0; b < NBANK; b++) begin
                  if (req_all || BA_W'(b) == req_bank) begin
                     pre_age_q[b] <= '0;
                     trp_need_q[b] <= CNT_W'(req_all ? TRP_AB : TRPPB_CYC);
                  end
               end
            end
         end
      end
   end
endmodule

/* src/btp_mem.sv */
`timescale 1ns/1ps
// Purpose: device end: decodes commands, stores write bytes, returns reads
// Assumes: controller keeps command spacing
// Notes:   small array stands in for the memory, one word per bank
module btp_mem
   import btp_pkg::*;
#(
   parameter int DW = 32,
   parameter int NB = DW / 8,
   parameter int RL = RL_DEFAULT,
   parameter int WL = WL_DEFAULT,
   parameter int BL = BL_DEFAULT,
   parameter int EIGHT_BANK = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   btp_if.mem lk,
   // status
   output logic [NBANK-1:0] bank_open,
   output logic [CNT_W-1:0] eff_bl
);
   import btp_pkg::*;
   localparam int PW = 32;
   logic [DW-1:0] mem_q [NBANK];
   logic [PW-1:0] wpipe_q, rpipe_q;
   logic [BA_W-1:0] wbank_q, rbank_q;
   logic [CNT_W-1:0] age_q;
   logic last_wr_q;
   logic burst_q;
   wire is_bst = !lk.cs_n && lk.ca[0] && lk.ca[1] && !lk.ca[2] && !lk.ca[3];
   wire is_pre = !lk.cs_n && lk.ca[0] && lk.ca[1] && !lk.ca[2] && lk.ca[3];
   wire is_wr = !lk.cs_n && lk.ca[0] && !lk.ca[1] && !lk.ca[2];
   wire is_rd = !lk.cs_n && lk.ca[0] && !lk.ca[1] && lk.ca[2];
   wire is_act = !lk.cs_n && !lk.ca[0] && !lk.ca[1];
   // bank select, top bit dropped on four banks
   wire [BA_W-1:0] cbank = EIGHT_BANK != 0 ? lk.ca[BA_LSB +: BA_W] : {1'b0, lk.ca[BA_LSB +: BA_W-1]};
   wire [PW-1:0] beats = (PW'(1) << (BL / 2)) - PW'(1);
   // terminate clears only latest burst's pending beats after latency
   wire [PW-1:0] wkeep = (PW'(1) << WL) - PW'(1);
   wire [PW-1:0] rkeep = (PW'(1) << RL) - PW'(1);
   wire wbeat = wpipe_q[0];
   wire rbeat = rpipe_q[0];
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wpipe_q <= '0;
         rpipe_q <= '0;
         wbank_q <= '0;
         rbank_q <= '0;
         age_q <= '0;
         last_wr_q <= 1'b0;
         burst_q <= 1'b0;
         bank_open <= '0;
         eff_bl <= '0;
         lk.rvalid <= 1'b0;
         lk.rdata <= '0;
      end else begin
         wpipe_q <= wpipe_q >> 1;
         rpipe_q <= rpipe_q >> 1;
         age_q <= age_q == CNT_MAX ? age_q : age_q + 8'h01;
         lk.rvalid <= rbeat;
         lk.rdata <= rbeat ? mem_q[rbank_q] : '0;
         if (burst_q && age_q + 8'h01 >= CNT_W'(BL / 2)) begin
            burst_q <= 1'b0;
         end
         // new write replaces pending beats in any bank
         if (is_wr) begin
            if (burst_q) begin
               eff_bl <= CNT_W'({age_q + 8'h01, 1'b0});
            end
            wpipe_q <= (wpipe_q >> 1) & ~(~PW'(0) << WL) | (beats << WL);
            wbank_q <= cbank;
            age_q <= '0;
            last_wr_q <= 1'b1;
            burst_q <= 1'b1;
         end else if (is_rd) begin
            rpipe_q <= (rpipe_q >> 1) & ~(~PW'(0) << RL) | (beats << RL);
            rbank_q <= cbank;
            age_q <= '0;
            last_wr_q <= 1'b0;
            burst_q <= 1'b1;
         end else if (is_bst && burst_q) begin
            eff_bl <= CNT_W'({age_q + 8'h01, 1'b0});
            burst_q <= 1'b0;
            if (last_wr_q) begin
               wpipe_q <= (wpipe_q >> 1) & wkeep;
            end else begin
               rpipe_q <= (rpipe_q >> 1) & rkeep;
            end
         end
         if (is_act) begin
            bank_open[cbank] <= 1'b1;
         end
         if (is_pre) begin
            if (lk.ca[AB_BIT]) begin
               bank_open <= '0;
            end else begin
               bank_open[cbank] <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (lk.wvalid && wbeat) begin
         for (int b = 0; b < NB; b++) begin
            if (!lk.dm[b]) begin
               mem_q[wbank_q][8*b +: 8] <= lk.wdata[8*b +: 8];
            end
         end
      end
   end
endmodule

/* tb/btp_monitor.sv */
`timescale 1ns/1ps
// Purpose: link checker for command decode and spacing
// Assumes: eight-bank device, one clock
// Notes:   ages count cycles since the last column, write, read and precharge command
module btp_monitor
   import btp_pkg::*;
#(
   parameter int BL = BL_DEFAULT,
   parameter int WL = WL_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   input wire logic cs_n,
   input wire logic [btp_pkg::CA_W-1:0] ca,
   input wire logic ap
);
   wire cmd = ~cs_n;
   wire col = cmd && ca[1:0] == 2'b01;
   wire wr = col && !ca[2];
   wire rd = col && ca[2];
   wire bst = cmd && ca[3:0] == 4'h3;
   wire pre = cmd && ca[3:0] == 4'hB;
   wire act = cmd && ca[1:0] == 2'b00;
   logic [7:0] age_q, wr_age_q, rd_age_q, pre_age_q, half_q;
   logic [2:0] wr_bank_q, rd_bank_q;
   logic last_wr_q, ap_q, bst_q, pre_all_q;
   wire live = age_q < 8'(BL / 2) && !bst_q;
   wire hit_wr = ca[AB_BIT] || ca[BA_LSB+:BA_W] == wr_bank_q;
   wire hit_rd = ca[AB_BIT] || ca[BA_LSB+:BA_W] == rd_bank_q;
   function automatic logic [7:0] inc(input logic [7:0] v);
      return (v == 8'hFF) ? v : v + 8'h01;
   endfunction
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {age_q, wr_age_q, rd_age_q, pre_age_q} <= 32'hFFFFFFFF;
         {half_q, wr_bank_q, rd_bank_q} <= 14'h0;
         {last_wr_q, ap_q, bst_q, pre_all_q} <= 4'h2;
      end else begin
         age_q <= col ? 8'h01 : inc(age_q);
         wr_age_q <= wr ? 8'h01 : inc(wr_age_q);
         rd_age_q <= rd ? 8'h01 : inc(rd_age_q);
         pre_age_q <= pre ? 8'h01 : inc(pre_age_q);
         half_q <= col ? 8'(BL / 2) : (bst ? age_q : half_q);
         last_wr_q <= col ? wr : last_wr_q;
         ap_q <= col ? ap : ap_q;
         bst_q <= col ? 1'b0 : (bst | bst_q);
         wr_bank_q <= wr ? ca[BA_LSB+:BA_W] : wr_bank_q;
         rd_bank_q <= rd ? ca[BA_LSB+:BA_W] : rd_bank_q;
         pre_all_q <= pre ? ca[AB_BIT] : pre_all_q;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_bst_even_gap:
      assert property (bst |-> age_q >= 8'h02 && !age_q[0] && age_q <= 8'(BL / 2 - 1))
      else $error("terminate outside its window");
   chk_bst_single:
      assert property (bst |-> !bst_q) else $error("second terminate");
   chk_wr_intr_gap:
      assert property (wr && last_wr_q && live |-> !age_q[0] && age_q >= 8'(TCCD_CYC) && BL != 4)
      else $error("bad write interrupt");
   chk_ap_no_intr:
      assert property ((wr || bst) && last_wr_q && live |-> !ap_q) else $error("auto-precharge write cut");
   chk_wr_cut_kind:
      assert property (cmd && last_wr_q && live |-> wr || bst) else $error("write cut by other command");
   chk_wr_to_pre:
      assert property (pre && last_wr_q && hit_wr |-> wr_age_q >= WL + half_q + 1 + TWR_CYC)
      else $error("precharge too soon after write");
   chk_rd_to_pre:
      assert property (pre && !last_wr_q && hit_rd |-> rd_age_q >= half_q && rd_age_q + 2 >= half_q + TRTP_CYC)
      else $error("precharge too soon after read");
   chk_act_after_pre:
      assert property (act |-> pre_age_q >= (pre_all_q ? TRPAB_CYC : TRPPB_CYC))
      else $error("activate too soon after precharge");
endmodule

/* tb/btp_test.sv */
`timescale 1ns/1ps
// Purpose: drives the controller user side, checks both ends
// Assumes: controller and device joined by one link
// Notes:   the controller spaces commands itself
module btp_test;
   import btp_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   btp_cmd_t req_cmd = BTP_NOP;
   logic [2:0] req_bank = 3'h0;
   logic req_all = 1'b0;
   logic req_ap = 1'b0;
   logic [31:0] req_wdata = 32'h0;
   logic [3:0] req_dm = 4'h0;
   logic req_ready, rd_valid;
   logic [31:0] rd_data;
   logic [7:0] bank_open, eff_bl;
   int err_count = 0, total_checks = 0, cyc = 0, t0, t1;
   btp_if lk_if();
   btp_ctrl btp_ctrl_inst(.clk(clk), .sys_rst(sys_rst), .lk(lk_if.ctrl), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_all(req_all), .req_ap(req_ap), .req_wdata(req_wdata),
      .req_dm(req_dm), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid));
   btp_mem btp_mem_inst(.clk(clk), .sys_rst(sys_rst), .lk(lk_if.mem), .bank_open(bank_open), .eff_bl(eff_bl));
   btp_monitor btp_monitor_inst(.clk(clk), .sys_rst(sys_rst), .cs_n(lk_if.cs_n), .ca(lk_if.ca), .ap(lk_if.ap));
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic req(input btp_cmd_t c, input logic [2:0] b, input logic all, input logic ap, output int t);
      int n = 0;
      @(negedge clk);
      {req_valid, req_cmd, req_bank, req_all, req_ap} = {1'b1, c, b, all, ap};
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) err_count++;
      t = cyc;
      req_valid = 1'b0;
   endtask
   task automatic wait_cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task t_mask;
      req(BTP_ACT, 3'h2, 1'b0, 1'b0, t0);
      wait_cyc(2);
      check(bank_open[2], 1'b1);
      {req_wdata, req_dm} = {32'h11223344, 4'h0};
      req(BTP_WR, 3'h2, 1'b0, 1'b0, t0);
      wait_cyc(8);
      {req_wdata, req_dm} = {32'hAABBCCDD, 4'h5};
      req(BTP_WR, 3'h2, 1'b0, 1'b0, t0);
      wait_cyc(8);
      req_dm = 4'h0;
      req(BTP_RD, 3'h2, 1'b0, 1'b0, t0);
      for (int n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge clk);
      check(rd_data, 32'hAA22CC44);
      $display("test mask done");
   endtask
   task t_bst;
      req(BTP_ACT, 3'h3, 1'b0, 1'b0, t0);
      req(BTP_WR, 3'h3, 1'b0, 1'b0, t0);
      req(BTP_BST, 3'h3, 1'b0, 1'b0, t1);
      check(32'(t1 - t0), 32'h2);
      wait_cyc(3);
      check(eff_bl, 8'(2 * (t1 - t0)));
      $display("test terminate done");
   endtask
   task t_intr;
      req(BTP_ACT, 3'h5, 1'b0, 1'b0, t0);
      wait_cyc(4);
      req(BTP_WR, 3'h3, 1'b0, 1'b0, t0);
      req(BTP_WR, 3'h5, 1'b0, 1'b0, t1);
      check(32'((t1 - t0) % 2), 32'h0);
      wait_cyc(3);
      check(eff_bl, 8'(2 * (t1 - t0)));
      $display("test interrupt done");
   endtask
   task t_pre;
      req(BTP_PRE, 3'h3, 1'b0, 1'b0, t1);
      check(32'(t1 - t0 >= WL_DEFAULT + 2 + 1 + TWR_CYC), 32'h1);
      wait_cyc(2);
      check({bank_open[3], bank_open[5]}, 2'b01);
      req(BTP_PRE, 3'h0, 1'b1, 1'b0, t1);
      wait_cyc(2);
      check(bank_open, 8'h00);
      $display("test precharge done");
   endtask
   task t_rdpre;
      req(BTP_ACT, 3'h1, 1'b0, 1'b0, t0);
      req(BTP_RD, 3'h1, 1'b0, 1'b0, t0);
      req(BTP_PRE, 3'h1, 1'b0, 1'b0, t1);
      check(32'(t1 - t0 >= BL_DEFAULT / 2), 32'h1);
      req(BTP_ACT, 3'h6, 1'b0, 1'b0, t0);
      check(32'(t0 - t1 >= TRPPB_CYC), 32'h1);
      req(BTP_WR, 3'h6, 1'b0, 1'b1, t0);
      req(BTP_WR, 3'h6, 1'b0, 1'b0, t1);
      check(32'(t1 - t0 >= BL_DEFAULT / 2), 32'h1);
      $display("test read precharge done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      wait_cyc(3);
      sys_rst = 1'b0;
      t_mask;
      t_bst;
      t_intr;
      t_pre;
      t_rdpre;
      end_of_test;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      end_of_test;
   end
endmodule
